// ===== shared/gisr_pkg.sv
// constants and carrier types for the general input, interrupt and boot status registers
package gisr_pkg;

  // bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIN_W  = 8;
  localparam int EV_W   = 4;

  // printed register offsets, kept as word indices
  localparam logic [ADDR_W-1:0] IDX_PIN      = 12'h219;
  localparam logic [ADDR_W-1:0] IDX_SUM      = 12'h21A;
  localparam logic [ADDR_W-1:0] IDX_BOOT     = 12'h21F;
  // interrupt block indices
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 12'h220;
  localparam logic [ADDR_W-1:0] IDX_IRQ_EN   = 12'h221;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLR  = 12'h222;

  // byte addresses on the bus, four times the index
  localparam logic [ADDR_W-1:0] ADDR_PIN      = IDX_PIN << 2;
  localparam logic [ADDR_W-1:0] ADDR_SUM      = IDX_SUM << 2;
  localparam logic [ADDR_W-1:0] ADDR_BOOT     = IDX_BOOT << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = IDX_IRQ_STAT << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = IDX_IRQ_EN << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = IDX_IRQ_CLR << 2;

  // field positions
  localparam int IRQ_SUM_BIT   = 0;
  localparam int BOOT_DONE_BIT = 0;
  localparam int BOOT_FAIL_BIT = 1;
  localparam int BOOT_CRC_BIT  = 3;

  // interrupt event bit positions
  localparam int EV_DONE = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_CRC  = 2;
  localparam int EV_PIN  = 3;

  // reset values
  localparam logic            CRC_OK_RST  = 1'b1;
  localparam logic            FLAG_RST    = 1'b0;
  localparam logic [EV_W-1:0] IRQ_EN_RST  = 4'h0;
  localparam logic [EV_W-1:0] IRQ_ST_RST  = 4'h0;
  localparam logic [PIN_W-1:0] PIN_RST    = 8'h00;

  // bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // master to slave signals of the register bus
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } gisr_axi_req_type;

  // slave to master signals of the register bus
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } gisr_axi_rsp_type;

endpackage : gisr_pkg

// ===== rtl/gisr_sync.sv
// two-stage synchroniser, one per input bit
`timescale 1ns/1ns
module gisr_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // raw levels and their synchronised copy
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // one synchroniser per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic stable_q;
    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q   <= 1'b0;
        stable_q <= 1'b0;
      end else begin
        meta_q   <= din[i];
        stable_q <= meta_q;
      end
    end
    assign dout[i] = stable_q;
  end

endmodule : gisr_sync

// ===== rtl/gisr_regs.sv
// general input, interrupt summary and boot status registers behind an axi4-lite slave
`timescale 1ns/1ns
module gisr_regs (
  // clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  // register bus
  input  wire gisr_pkg::gisr_axi_req_type      axi_req,
  output gisr_pkg::gisr_axi_rsp_type           axi_rsp,
  // general-purpose pins
  input  wire logic [gisr_pkg::PIN_W-1:0]      gpio_in,
  input  wire logic [gisr_pkg::PIN_W-1:0]      gpio_is_input,
  // eeprom loader events, one-cycle pulses
  input  wire logic                            boot_done_evt,
  input  wire logic                            boot_fail_evt,
  input  wire logic                            boot_crc_err_evt,
  // status outputs
  output logic                                 irq_out_n,
  output logic                                 irq,
  output logic                                 serial_port_locked,
  output logic                                 boot_load_done,
  output logic                                 boot_load_failed,
  output logic                                 boot_crc_ok
);

  // synchronised pins and latched field
  logic [gisr_pkg::PIN_W-1:0] pin_sync;
  logic [gisr_pkg::PIN_W-1:0] general_input_levels_q;
  logic [gisr_pkg::PIN_W-1:0] general_input_levels_d;

  // boot flags
  logic boot_load_done_q;
  logic boot_load_failed_q;
  logic boot_crc_ok_q;
  logic port_locked_q;

  // interrupt block
  logic [gisr_pkg::EV_W-1:0] irq_stat_q;
  logic [gisr_pkg::EV_W-1:0] irq_en_q;
  logic [gisr_pkg::EV_W-1:0] irq_ev;
  logic [gisr_pkg::EV_W-1:0] irq_clr;
  logic                      irq_sum;
  logic                      irq_out_n_q;
  logic                      irq_q;

  // write channel state
  logic                          awready_q;
  logic                          wready_q;
  logic                          aw_full_q;
  logic                          w_full_q;
  logic [gisr_pkg::ADDR_W-1:0]   aw_addr_q;
  logic [gisr_pkg::DATA_W-1:0]   wdata_q;
  logic [3:0]                    wstrb_q;
  logic                          bvalid_q;
  logic [1:0]                    bresp_q;
  logic                          aw_take;
  logic                          w_take;
  logic                          wr_fire;
  logic                          wr_ok;
  logic [1:0]                    wr_resp;

  // read channel state
  logic                          arready_q;
  logic                          rvalid_q;
  logic [gisr_pkg::DATA_W-1:0]   rdata_q;
  logic [1:0]                    rresp_q;
  logic                          ar_take;
  logic [gisr_pkg::DATA_W-1:0]   rd_data;
  logic [1:0]                    rd_resp;

  gisr_sync #(
    .WIDTH (gisr_pkg::PIN_W)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (gpio_in),
    .dout    (pin_sync)
  );

  assign general_input_levels_d = pin_sync & gpio_is_input;

  // general input field
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_input_levels_q <= gisr_pkg::PIN_RST;
    end else begin
      general_input_levels_q <= general_input_levels_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_load_done_q <= gisr_pkg::FLAG_RST;
    end else if (boot_done_evt) begin
      boot_load_done_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_load_failed_q <= gisr_pkg::FLAG_RST;
    end else if (boot_fail_evt) begin
      boot_load_failed_q <= 1'b1;
    end
  end

  // crc error clears active-low bit; it stays 0 until reset, which loads 1
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_crc_ok_q <= gisr_pkg::CRC_OK_RST;
    end else if (boot_crc_err_evt) begin
      boot_crc_ok_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_locked_q <= 1'b0;
    end else if (boot_crc_err_evt) begin
      port_locked_q <= 1'b1;
    end
  end

  // interrupt events: done and fail flag rising edges, crc bit falling edge and input changes
  always_comb begin
    irq_ev                    = '0;
    irq_ev[gisr_pkg::EV_DONE] = boot_done_evt & ~boot_load_done_q;
    irq_ev[gisr_pkg::EV_FAIL] = boot_fail_evt & ~boot_load_failed_q;
    irq_ev[gisr_pkg::EV_CRC]  = boot_crc_err_evt & boot_crc_ok_q;
    irq_ev[gisr_pkg::EV_PIN]  = |(general_input_levels_d ^ general_input_levels_q);
  end

  // write-one-to-clear mask
  assign irq_clr = (wr_fire && wr_ok && aw_addr_q == gisr_pkg::ADDR_IRQ_CLR && wstrb_q[0])
                   ? wdata_q[gisr_pkg::EV_W-1:0] : '0;

  // sticky status, a new event wins over a clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= gisr_pkg::IRQ_ST_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end
  end

  // enable register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= gisr_pkg::IRQ_EN_RST;
    end else if (wr_fire && wr_ok && aw_addr_q == gisr_pkg::ADDR_IRQ_EN && wstrb_q[0]) begin
      irq_en_q <= wdata_q[gisr_pkg::EV_W-1:0];
    end
  end

  assign irq_sum = |(irq_stat_q & irq_en_q);

  // interrupt pin low from the cycle after summary set, registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out_n_q <= 1'b1;
      irq_q       <= 1'b0;
    end else begin
      irq_out_n_q <= ~irq_sum;
      irq_q       <= irq_sum;
    end
  end

  // handshakes
  assign aw_take = axi_req.awvalid & awready_q;
  assign w_take  = axi_req.wvalid & wready_q;
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign ar_take = axi_req.arvalid & arready_q;

  // write decode: lock refuses, unmapped is a decode error
  always_comb begin
    wr_ok   = 1'b0;
    wr_resp = gisr_pkg::RESP_DECERR;
    case (aw_addr_q)
      gisr_pkg::ADDR_PIN, gisr_pkg::ADDR_SUM, gisr_pkg::ADDR_BOOT,
      gisr_pkg::ADDR_IRQ_STAT, gisr_pkg::ADDR_IRQ_EN, gisr_pkg::ADDR_IRQ_CLR: begin
        wr_ok   = ~port_locked_q;
        wr_resp = port_locked_q ? gisr_pkg::RESP_SLVERR : gisr_pkg::RESP_OKAY;
      end
      default: begin
        wr_ok   = 1'b0;
        wr_resp = gisr_pkg::RESP_DECERR;
      end
    endcase
  end

  // write address capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else begin
      if (aw_take) begin
        awready_q <= 1'b0;
        aw_full_q <= 1'b1;
        aw_addr_q <= axi_req.awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end else if (bvalid_q && axi_req.bready) begin
        awready_q <= 1'b1;
      end
    end
  end

  // write data capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (w_take) begin
        wready_q <= 1'b0;
        w_full_q <= 1'b1;
        wdata_q  <= axi_req.wdata;
        wstrb_q  <= axi_req.wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end else if (bvalid_q && axi_req.bready) begin
        wready_q <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= gisr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_resp;
    end else if (axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read mux, reserved bits read zero
  always_comb begin
    rd_data = '0;
    rd_resp = gisr_pkg::RESP_OKAY;
    case (axi_req.araddr)
      gisr_pkg::ADDR_PIN: begin
        rd_data[gisr_pkg::PIN_W-1:0] = general_input_levels_q;
      end
      gisr_pkg::ADDR_SUM: begin
        rd_data[gisr_pkg::IRQ_SUM_BIT] = irq_sum;
      end
      gisr_pkg::ADDR_BOOT: begin
        rd_data[gisr_pkg::BOOT_DONE_BIT] = boot_load_done_q;
        rd_data[gisr_pkg::BOOT_FAIL_BIT] = boot_load_failed_q;
        rd_data[gisr_pkg::BOOT_CRC_BIT]  = boot_crc_ok_q;
      end
      gisr_pkg::ADDR_IRQ_STAT: begin
        rd_data[gisr_pkg::EV_W-1:0] = irq_stat_q;
      end
      gisr_pkg::ADDR_IRQ_EN: begin
        rd_data[gisr_pkg::EV_W-1:0] = irq_en_q;
      end
      gisr_pkg::ADDR_IRQ_CLR: begin
        rd_data = '0;
      end
      default: begin
        rd_resp = gisr_pkg::RESP_DECERR;
      end
    endcase
  end

  // read channel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= gisr_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_resp;
    end else if (rvalid_q && axi_req.rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // bus outputs, all from flops
  assign axi_rsp.awready = awready_q;
  assign axi_rsp.wready  = wready_q;
  assign axi_rsp.bvalid  = bvalid_q;
  assign axi_rsp.bresp   = bresp_q;
  assign axi_rsp.arready = arready_q;
  assign axi_rsp.rvalid  = rvalid_q;
  assign axi_rsp.rdata   = rdata_q;
  assign axi_rsp.rresp   = rresp_q;

  // status pins
  assign irq_out_n          = irq_out_n_q;
  assign irq                = irq_q;
  assign serial_port_locked = port_locked_q;
  assign boot_load_done     = boot_load_done_q;
  assign boot_load_failed   = boot_load_failed_q;
  assign boot_crc_ok        = boot_crc_ok_q;

endmodule : gisr_regs

// ===== test/gisr_regs_monitor.sv
// port assertions for the status register block
`timescale 1ns/1ns
module gisr_regs_monitor (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  // bus and loader events
  input wire gisr_pkg::gisr_axi_req_type axi_req,
  input wire gisr_pkg::gisr_axi_rsp_type axi_rsp,
  input wire logic                       boot_done_evt,
  input wire logic                       boot_fail_evt,
  input wire logic                       boot_crc_err_evt,
  // status outputs
  input wire logic                       irq_out_n,
  input wire logic                       irq,
  input wire logic                       serial_port_locked,
  input wire logic                       boot_load_done,
  input wire logic                       boot_load_failed,
  input wire logic                       boot_crc_ok
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // pin is the inverse of summary
  irq_pin_a: assert property (irq_out_n == !irq)
    else $error("interrupt pin disagrees with summary");
  done_set_a: assert property (boot_done_evt |=> boot_load_done)
    else $error("done flag not set");
  done_hold_a: assert property (boot_load_done |=> boot_load_done)
    else $error("done flag dropped");
  fail_set_a: assert property (boot_fail_evt |=> boot_load_failed)
    else $error("fail flag not set");
  fail_hold_a: assert property (boot_load_failed |=> boot_load_failed)
    else $error("fail flag dropped");
  crc_lock_a: assert property (boot_crc_err_evt |=> !boot_crc_ok && serial_port_locked)
    else $error("crc error not reported");
  crc_hold_a: assert property (!boot_crc_ok |=> !boot_crc_ok && serial_port_locked)
    else $error("crc error dropped");
  // crc bit falls only on error
  crc_cause_a: assert property ($fell(boot_crc_ok) |-> $past(boot_crc_err_evt))
    else $error("crc bit fell without error");
  lock_resp_a: assert property (serial_port_locked && axi_req.awvalid && axi_rsp.awready
    && axi_req.wvalid && axi_rsp.wready && axi_req.awaddr == gisr_pkg::ADDR_IRQ_EN
    |-> ##2 axi_rsp.bvalid && axi_rsp.bresp == gisr_pkg::RESP_SLVERR)
    else $error("locked write not refused");
endmodule : gisr_regs_monitor

bind gisr_regs gisr_regs_monitor gisr_regs_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .boot_done_evt(boot_done_evt),
  .boot_fail_evt(boot_fail_evt), .boot_crc_err_evt(boot_crc_err_evt),
  .irq_out_n(irq_out_n), .irq(irq), .serial_port_locked(serial_port_locked),
  .boot_load_done(boot_load_done), .boot_load_failed(boot_load_failed),
  .boot_crc_ok(boot_crc_ok));

// ===== test/gisr_host.sv
// host model acting as the register bus master
`timescale 1ns/1ns
module gisr_host (
  // clock
  input wire logic                       sys_clk,
  // register bus
  output gisr_pkg::gisr_axi_req_type     req,
  input wire gisr_pkg::gisr_axi_rsp_type rsp
);
  initial req = '0;

  // count a hang and end the run
  task automatic hang();
    gisr_regs_tb.num_errors++;
    gisr_regs_tb.print_verdict();
  endtask : hang

  // write the low byte of a word, upper bytes sent as zero, each channel held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.awaddr <= a;
    req.wdata <= dv & 32'hFF;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 200);
    rs = rsp.bresp;
    req.bready <= 1'b0;
    if (n >= 200) hang();
  endtask : wr

  // read one word, address held until taken
  task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 200);
    dv = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
    if (n >= 200) hang();
  endtask : rd
endmodule : gisr_host

// ===== test/gisr_regs_tb.sv
// self-checking bench for the status register block
`timescale 1ns/1ns
module gisr_regs_tb;
  logic sys_clk, rst_n, done_e, fail_e, crc_e, irq_out_n, irq, locked, done, failed, crc_ok;
  logic [7:0] gpio_in, gpio_is_input;
  gisr_pkg::gisr_axi_req_type req;
  gisr_pkg::gisr_axi_rsp_type rsp;
  logic [31:0] d;
  logic [1:0] r;
  int num_errors, check_count;

  gisr_regs gisr_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
    .gpio_in(gpio_in), .gpio_is_input(gpio_is_input), .boot_done_evt(done_e),
    .boot_fail_evt(fail_e), .boot_crc_err_evt(crc_e), .irq_out_n(irq_out_n), .irq(irq),
    .serial_port_locked(locked), .boot_load_done(done), .boot_load_failed(failed),
    .boot_crc_ok(crc_ok));
  gisr_host gisr_host_i (.sys_clk(sys_clk), .req(req), .rsp(rsp));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD at %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // read, expect OKAY, compare defined bits only
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    gisr_host_i.rd(a, d, r);
    check({30'h0, r}, 32'h0);
    check(d & m, e);
  endtask : rdc

  // one-cycle loader event: 0 done, 1 fail, 2 crc
  task automatic pulse(input int k);
    @(posedge sys_clk);
    done_e <= (k == 0);
    fail_e <= (k == 1);
    crc_e <= (k == 2);
    @(posedge sys_clk);
    {done_e, fail_e, crc_e} <= 3'h0;
  endtask : pulse

  task automatic t_reset();
    check({31'h0, irq_out_n}, 32'h1);
    rdc(gisr_pkg::ADDR_SUM, 32'h1, 32'h0);
    rdc(gisr_pkg::ADDR_BOOT, 32'hB, 32'h8);
    $display("test reset done");
  endtask : t_reset

  task automatic t_inputs();
    @(posedge sys_clk);
    gpio_is_input <= 8'hF0;
    gpio_in <= 8'hA5;
    repeat (4) @(posedge sys_clk);
    rdc(gisr_pkg::ADDR_PIN, 32'hFF, 32'hA0);
    rdc(gisr_pkg::ADDR_IRQ_STAT, 32'h8, 32'h8);
    rdc(gisr_pkg::ADDR_SUM, 32'h1, 32'h0);
    $display("test inputs done");
  endtask : t_inputs

  task automatic t_irq();
    gisr_host_i.wr(gisr_pkg::ADDR_IRQ_EN, 32'h1, r);
    check({30'h0, r}, 32'h0);
    pulse(0);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq_out_n}, 32'h0);
    rdc(gisr_pkg::ADDR_SUM, 32'h1, 32'h1);
    gisr_host_i.wr(gisr_pkg::ADDR_IRQ_CLR, 32'h1, r);
    check({30'h0, r}, 32'h0);
    rdc(gisr_pkg::ADDR_SUM, 32'h1, 32'h0);
    check({31'h0, irq_out_n}, 32'h1);
    rdc(gisr_pkg::ADDR_BOOT, 32'hB, 32'h9);
    gisr_host_i.rd(12'h000, d, r);
    check({30'h0, r}, 32'h3);
    $display("test irq done");
  endtask : t_irq

  task automatic t_crc();
    pulse(1);
    rdc(gisr_pkg::ADDR_BOOT, 32'hB, 32'hB);
    pulse(2);
    rdc(gisr_pkg::ADDR_BOOT, 32'hB, 32'h3);
    gisr_host_i.wr(gisr_pkg::ADDR_IRQ_EN, 32'h0, r);
    check({30'h0, r}, 32'h2);
    rdc(gisr_pkg::ADDR_IRQ_EN, 32'hF, 32'h1);
    // hardware reset to retry the load
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(gisr_pkg::ADDR_BOOT, 32'hB, 32'h8);
    $display("test crc done");
  endtask : t_crc

  // main sequence
  initial begin
    rst_n = 1'b0;
    gpio_in = 8'h00;
    gpio_is_input = 8'h00;
    {done_e, fail_e, crc_e} = 3'h0;
    num_errors = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_inputs();
    t_irq();
    t_crc();
    print_verdict();
  end
endmodule : gisr_regs_tb
